// ===== design/asc_consts.svh
/*
  constants of the adc sample conditioning block: register addresses,
  reset values, field positions and channel numbers.
  assumes inclusion by the package, the design module and the testbench.
*/
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
// register addresses (7-bit word addresses)
`define ASC_ADR_RAW 7'h02
`define ASC_ADR_SEL 7'h03
`define ASC_ADR_STAGE 7'h04
`define ASC_ADR_DECIM 7'h05
`define ASC_ADR_CAL0 7'h06
`define ASC_ADR_RES_I 7'h0B
`define ASC_ADR_RES_I2 7'h0C
`define ASC_ADR_RES_UV 7'h0D
`define ASC_ADR_RES_W 7'h0E
`define ASC_ADR_BRAKE 7'h0F
`define ASC_ADR_EXT 7'h10
`define ASC_ADR_CTRL 7'h11
`define ASC_ADR_STAT 7'h12
// reset values
`define ASC_STAGE_RST 32'h0000_0000
`define ASC_DECIM_RST 16'h0100
`define ASC_OFS_RST 16'h8000
`define ASC_SCL_RST 16'h0100
`define ASC_BRAKE_ON_RST 16'hFFFF
`define ASC_BRAKE_OFF_RST 16'h0000
// field positions
`define ASC_CTRL_EXT 0
`define ASC_CTRL_SPIF 1
`define ASC_HI 31:16
`define ASC_LO 15:0
// scaling: factor is q8.8, clipped to the symmetric s16 range
`define ASC_SCL_SHIFT 8
`define ASC_S16_MAX 33'sh0_0000_7FFF
`define ASC_S16_MIN -33'sh0_0000_7FFF
// channel numbers, equal to the nibble index in the stage word
`define ASC_CH_I0 0
`define ASC_CH_I1 1
`define ASC_CH_VM 2
`define ASC_CH_GPA 3
`define ASC_CH_GPB 4
`define ASC_CH_U 5
`define ASC_CH_V 6
`define ASC_CH_W 7
`define ASC_NCH 8
`define ASC_NCAL 5
`endif

// ===== design/asc_pkg.sv
/*
  types of the adc sample conditioning block.
  assumes asc_consts.svh on the include path.
*/
`include "asc_consts.svh"
package asc_pkg;
  typedef logic [15:0] asc_word_t;
  // input stage codes per channel
  typedef enum logic [2:0] {
    ASC_STG_DIFF = 3'h0,
    ASC_STG_NEG_GND = 3'h1,
    ASC_STG_REF_Q1 = 3'h2,
    ASC_STG_REF_Q3 = 3'h3,
    ASC_STG_POS_GND = 3'h4,
    ASC_STG_REF_HALF = 3'h5
  } asc_stage_e;
  // readout window selector codes
  typedef enum logic [2:0] {
    ASC_SEL_CUR = 3'h0,
    ASC_SEL_VM_GPA = 3'h1,
    ASC_SEL_GPB_U = 3'h2,
    ASC_SEL_V_W = 3'h3,
    ASC_SEL_I2 = 3'h4
  } asc_sel_e;
endpackage

// ===== design/asc_sample_cond.sv
/*
  adc sample conditioning: decimation strobes, raw latches, offset and scale
  to s16, derived third current, readout window, stage word, brake chopper.
  assumes filtered values and modulator ticks synchronous to clock; one
  register access a cycle, read data valid the cycle after the read strobe.
*/
// Operation
// [R1] eight channels: two currents, three encoder, supply, two general inputs
// [R2] third current equals negated sum of the two measured currents
// [R3] single-ended current channel ties negative input to ground
// [R4] encoder zero channel readable but never zeroes position
// [R5] supply channel offered only as unscaled raw value
// [R6] brake output switches on raw supply versus on/off thresholds
// [R7] software current values may replace sampled raw currents
// [R8] general inputs raw; first may feed single-pin target value
// [R9] readout window shows raw samples picked by the selector register
// [R10] current samples converted to s16 two's complement
// [R11] offset is unsigned and subtracted from the raw sample
// [R12] scale is signed; negative value inverts direction
// [R13] scaled current and encoder results readable in registers
// [R14] all channels processed in parallel, no multiplexing
// [R15] 3-bit stage code per channel; code 0 differential, reset value
// [R16] code 1 converts negative input against ground, test only
// [R17] code 4 converts positive input against ground
// [R18] codes 2, 3, 5 select quarter, three-quarter, half reference
// [R19] new raw sample per group after decimation count of clock ticks
// [R20] stage fields sit every fourth bit from 0 to 28 in one word
// [R21] scaled and derived results update with the new raw sample
`timescale 1ns/100ps
`default_nettype none
`include "asc_consts.svh"
module asc_sample_cond
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // modulator side: filtered values and clock ticks per group
  input wire logic [7:0][15:0] filt_data,
  input wire logic mclk_tick_a,
  input wire logic mclk_tick_b,
  // analog front-end controls
  output logic [31:0] input_stage_word,
  output logic [7:0] neg_to_gnd,
  output logic [7:0] pos_to_gnd,
  output logic [7:0] ref_sel,
  // consumers
  output logic brake_chopper,
  output logic [15:0] spif_target,
  output logic spif_target_en
);
  import asc_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // symmetric clip to s16; the most negative code is avoided
  function automatic asc_word_t asc_clip(input logic signed [32:0] v);
    logic signed [32:0] c;
    c = (v > `ASC_S16_MAX) ? `ASC_S16_MAX : ((v < `ASC_S16_MIN) ? `ASC_S16_MIN : v);
    return c[15:0];
  endfunction
  // true when a channel's stage code matches the given code
  function automatic logic asc_is(input logic [2:0] code, input asc_stage_e s);
    return code == s;
  endfunction
  // ************************************************************
  // registers written by software
  // ************************************************************
  logic [31:0] stage_ff;
  logic [15:0] decim_a_ff;
  logic [15:0] decim_b_ff;
  logic [31:0] cal_ff [`ASC_NCAL];
  logic [15:0] brake_on_ff;
  logic [15:0] brake_off_ff;
  logic [31:0] ext_ff;
  logic [1:0] ctrl_ff;
  asc_sel_e sel_ff;
  logic wr_stage;
  assign wr_stage = reg_wr && (reg_addr == `ASC_ADR_STAGE);
  // stage word resets to all-differential; see [R15] [R20]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stage_ff <= `ASC_STAGE_RST;
    else if (wr_stage)
      stage_ff <= reg_wdata;
  end
  // configuration words; one write port so no two writers collide
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decim_a_ff <= `ASC_DECIM_RST;
      decim_b_ff <= `ASC_DECIM_RST;
      brake_on_ff <= `ASC_BRAKE_ON_RST;
      brake_off_ff <= `ASC_BRAKE_OFF_RST;
      ext_ff <= 32'h0000_0000;
      ctrl_ff <= 2'h0;
      sel_ff <= ASC_SEL_CUR;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ASC_ADR_DECIM:
        begin
          decim_a_ff <= reg_wdata[`ASC_LO];
          decim_b_ff <= reg_wdata[`ASC_HI];
        end
        `ASC_ADR_BRAKE:
        begin
          brake_off_ff <= reg_wdata[`ASC_LO];
          brake_on_ff <= reg_wdata[`ASC_HI];
        end
        `ASC_ADR_EXT: ext_ff <= reg_wdata;
        `ASC_ADR_CTRL: ctrl_ff <= reg_wdata[1:0];
        `ASC_ADR_SEL: sel_ff <= asc_sel_e'(reg_wdata[2:0]); // see [R9]
        default: ;
      endcase
    end
  end

  // offset (low half, unsigned) and scale (high half, signed)
  generate
    for (genvar k = 0; k < `ASC_NCAL; k++)
    begin : g_cal
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          cal_ff[k] <= {`ASC_SCL_RST, `ASC_OFS_RST};
        else if (reg_wr && (reg_addr == `ASC_ADR_CAL0 + 7'(k)))
          cal_ff[k] <= reg_wdata;
      end
    end
  endgenerate
  // ************************************************************
  // decimation strobes, one counter per group
  // ************************************************************
  logic [15:0] dcnt_ff [2];
  logic [1:0] strobe;
  logic [1:0] tick;
  logic [15:0] decim [2];
  assign tick = {mclk_tick_b, mclk_tick_a};
  assign decim[0] = decim_a_ff;
  assign decim[1] = decim_b_ff;
  // a count of zero behaves like one so the group never stalls
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_dec
      assign strobe[g] = tick[g] && (dcnt_ff[g] + 16'h0001 >= decim[g]);
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          dcnt_ff[g] <= 16'h0000;
        else if (strobe[g])
          dcnt_ff[g] <= 16'h0000; // see [R19]
        else if (tick[g])
          dcnt_ff[g] <= dcnt_ff[g] + 16'h0001;
      end
    end
  endgenerate
  // ************************************************************
  // raw sample latches, all channels side by side
  // ************************************************************
  asc_word_t raw_ff [`ASC_NCH];
  asc_word_t nxt_raw [`ASC_NCH];
  // group a holds currents, supply, first general input
  generate
    for (genvar c = 0; c < `ASC_NCH; c++)
    begin : g_raw
      localparam int GRP = (c < `ASC_CH_GPB) ? 0 : 1;
      always_comb
      begin
        nxt_raw[c] = raw_ff[c];
        if (strobe[GRP])
        begin
          nxt_raw[c] = filt_data[c]; // see [R1] [R14]
          if (ctrl_ff[`ASC_CTRL_EXT] && c == `ASC_CH_I0)
            nxt_raw[c] = ext_ff[`ASC_LO]; // see [R7]
          if (ctrl_ff[`ASC_CTRL_EXT] && c == `ASC_CH_I1)
            nxt_raw[c] = ext_ff[`ASC_HI]; // see [R7]
        end
      end
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          raw_ff[c] <= 16'h0000;
        else
          raw_ff[c] <= nxt_raw[c]; // see [R5] [R8]
      end
    end
  endgenerate
  // ************************************************************
  // offset and scale; computed from the incoming sample so results
  // land in the same cycle as the raw latch
  // ************************************************************
  asc_word_t res_ff [`ASC_NCAL];
  asc_word_t nxt_res [`ASC_NCAL];
  asc_word_t i2_ff;
  generate
    for (genvar k = 0; k < `ASC_NCAL; k++)
    begin : g_scl
      localparam int CH = (k < 2) ? k : k + 3;
      localparam int GRP = (k < 2) ? 0 : 1;
      logic signed [16:0] diff;
      logic signed [32:0] prod;
      assign diff = $signed({1'b0, nxt_raw[CH]})
        - $signed({1'b0, cal_ff[k][`ASC_LO]}); // see [R11]
      assign prod = 33'(diff) * 33'($signed(cal_ff[k][`ASC_HI])); // see [R12]
      assign nxt_res[k] = asc_clip(prod >>> `ASC_SCL_SHIFT); // see [R10]
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          res_ff[k] <= 16'h0000;
        else if (strobe[GRP])
          res_ff[k] <= nxt_res[k]; // see [R13] [R21]
      end
    end
  endgenerate
  // third current from the two scaled currents of the same sample
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      i2_ff <= 16'h0000;
    else if (strobe[0])
      i2_ff <= asc_clip(-(33'(signed'(nxt_res[0])) + 33'(signed'(nxt_res[1])))); // see [R2]
  end
  // ************************************************************
  // brake chopper, single-pin target, front-end controls
  // ************************************************************
  logic brake_ff;
  // on wins over off when thresholds overlap, keeping the bus safe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      brake_ff <= 1'b0;
    else if (raw_ff[`ASC_CH_VM] >= brake_on_ff)
      brake_ff <= 1'b1; // see [R6]
    else if (raw_ff[`ASC_CH_VM] <= brake_off_ff)
      brake_ff <= 1'b0; // see [R6]
  end
  assign brake_chopper = brake_ff;
  // the zero-pulse channel only reaches the readout path, nothing else
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spif_target <= 16'h0000;
      spif_target_en <= 1'b0;
    end
    else
    begin
      spif_target_en <= ctrl_ff[`ASC_CTRL_SPIF]; // see [R8] [R4]
      spif_target <= ctrl_ff[`ASC_CTRL_SPIF] ? raw_ff[`ASC_CH_GPA] : 16'h0000;
    end
  end

  // per-channel switch controls decoded from the stage word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      neg_to_gnd <= 8'h00;
      pos_to_gnd <= 8'h00;
      ref_sel <= 8'h00;
    end
    else
    begin
      for (int c = 0; c < `ASC_NCH; c++)
      begin
        neg_to_gnd[c] <= asc_is(stage_ff[4*c +: 3], ASC_STG_POS_GND); // see [R3] [R17]
        pos_to_gnd[c] <= asc_is(stage_ff[4*c +: 3], ASC_STG_NEG_GND); // see [R16]
        ref_sel[c] <= asc_is(stage_ff[4*c +: 3], ASC_STG_REF_Q1)
          || asc_is(stage_ff[4*c +: 3], ASC_STG_REF_Q3)
          || asc_is(stage_ff[4*c +: 3], ASC_STG_REF_HALF); // see [R18]
      end
    end
  end
  assign input_stage_word = stage_ff; // see [R20]
  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      `ASC_ADR_RAW:
        case (sel_ff) // see [R9]
          ASC_SEL_CUR: nxt_rdata = {raw_ff[`ASC_CH_I1], raw_ff[`ASC_CH_I0]};
          ASC_SEL_VM_GPA: nxt_rdata = {raw_ff[`ASC_CH_GPA], raw_ff[`ASC_CH_VM]};
          ASC_SEL_GPB_U: nxt_rdata = {raw_ff[`ASC_CH_U], raw_ff[`ASC_CH_GPB]};
          ASC_SEL_V_W: nxt_rdata = {raw_ff[`ASC_CH_W], raw_ff[`ASC_CH_V]};
          ASC_SEL_I2: nxt_rdata = {16'h0000, i2_ff};
          default: nxt_rdata = 32'h0000_0000;
        endcase
      `ASC_ADR_SEL: nxt_rdata = {29'h0, sel_ff};
      `ASC_ADR_STAGE: nxt_rdata = stage_ff;
      `ASC_ADR_DECIM: nxt_rdata = {decim_b_ff, decim_a_ff};
      `ASC_ADR_RES_I: nxt_rdata = {res_ff[1], res_ff[0]}; // see [R13]
      `ASC_ADR_RES_I2: nxt_rdata = {16'h0000, i2_ff};
      `ASC_ADR_RES_UV: nxt_rdata = {res_ff[3], res_ff[2]};
      `ASC_ADR_RES_W: nxt_rdata = {16'h0000, res_ff[4]};
      `ASC_ADR_BRAKE: nxt_rdata = {brake_on_ff, brake_off_ff};
      `ASC_ADR_EXT: nxt_rdata = ext_ff;
      `ASC_ADR_CTRL: nxt_rdata = {30'h0, ctrl_ff};
      `ASC_ADR_STAT: nxt_rdata = {31'h0, brake_ff};
      default:
        if (reg_addr >= `ASC_ADR_CAL0 && reg_addr < `ASC_ADR_RES_I)
          nxt_rdata = cal_ff[3'(reg_addr - `ASC_ADR_CAL0)];
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= nxt_rdata;
  end
  // ************************************************************
  // checks
  // ************************************************************
  brake_set_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R6]
    raw_ff[`ASC_CH_VM] >= brake_on_ff |=> brake_chopper)
    else $error("brake not switched on");
  brake_clr_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R6]
    raw_ff[`ASC_CH_VM] < brake_on_ff && raw_ff[`ASC_CH_VM] <= brake_off_ff
    |=> !brake_chopper)
    else $error("brake not switched off");
  derived_cur_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R2]
    strobe[0] |=> i2_ff == asc_clip(-(33'(signed'(res_ff[0]))
    + 33'(signed'(res_ff[1])))))
    else $error("third current mismatch");
  decim_strobe_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R19]
    tick[0] && decim_a_ff > 16'h0001 && dcnt_ff[0] == decim_a_ff - 16'h0001
    |-> strobe[0] ##1 dcnt_ff[0] == 16'h0000)
    else $error("decimation strobe missed");
  stage_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R20]
    !wr_stage |=> $stable(input_stage_word))
    else $error("stage word changed without write");
  supply_raw_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R5]
    strobe[0] |=> raw_ff[`ASC_CH_VM] == $past(filt_data[`ASC_CH_VM]))
    else $error("supply raw not latched");
  ext_cur_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R7]
    strobe[0] && ctrl_ff[`ASC_CTRL_EXT] |=> raw_ff[`ASC_CH_I0] == $past(ext_ff[15:0]))
    else $error("external current not used");
  raw_window_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R9]
    reg_rd && reg_addr == `ASC_ADR_RAW && sel_ff == ASC_SEL_CUR
    |=> reg_rdata == $past({raw_ff[1], raw_ff[0]}))
    else $error("raw window wrong");
  single_end_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R3]
    stage_ff[2:0] == 3'h4 |=> neg_to_gnd[0] && !pos_to_gnd[0])
    else $error("negative input not grounded");
  scaled_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // see [R21]
    !strobe[1] |=> $stable(res_ff[2]))
    else $error("encoder result moved without sample");
endmodule
`default_nettype wire

// ===== test/asc_frontend_model.sv
/*
  model of the analog front-ends: filtered values per channel and
  modulator clock ticks per group.
  assumes the bench sets levels and run flags at the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module asc_frontend_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bench control
  input wire logic [7:0][15:0] levels,
  input wire logic run_a,
  input wire logic run_b,
  // towards the block
  output logic [7:0][15:0] filt_data,
  output logic mclk_tick_a,
  output logic mclk_tick_b
);
  // ************************************
  // tick dividers
  // ************************************
  logic [1:0] div_a_ff;
  logic [1:0] div_b_ff;

  // ticks stand still while a group is stopped, so tick counts stay exact
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_a_ff <= 2'h0;
      div_b_ff <= 2'h0;
    end
    else
    begin
      div_a_ff <= run_a ? div_a_ff + 2'h1 : 2'h0;
      div_b_ff <= run_b ? div_b_ff + 2'h1 : 2'h0;
    end
  end

  // one tick every fourth cycle while running
  assign mclk_tick_a = run_a && (div_a_ff == 2'h3);
  assign mclk_tick_b = run_b && (div_b_ff == 2'h3);
  // filter output follows the input level
  assign filt_data = levels;
endmodule
`default_nettype wire

// ===== test/testbench.sv
/*
  self-checking bench of the adc sample conditioning block.
  assumes asc_consts.svh on the include path and the front-end model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "asc_consts.svh"
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  logic clock;
  logic rst_n;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0][15:0] levels;
  logic [7:0][15:0] filt_data;
  logic run_a;
  logic run_b;
  logic mclk_tick_a;
  logic mclk_tick_b;
  logic [31:0] input_stage_word;
  logic [7:0] neg_to_gnd;
  logic [7:0] pos_to_gnd;
  logic [7:0] ref_sel;
  logic brake_chopper;
  logic [15:0] spif_target;
  logic spif_target_en;
  int fails;
  int comparisons;
  int cycles;

  // ************************************
  // instances
  // ************************************
  asc_sample_cond asc_sample_cond_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .filt_data(filt_data), .mclk_tick_a(mclk_tick_a), .mclk_tick_b(mclk_tick_b),
    .input_stage_word(input_stage_word), .neg_to_gnd(neg_to_gnd), .pos_to_gnd(pos_to_gnd),
    .ref_sel(ref_sel), .brake_chopper(brake_chopper), .spif_target(spif_target),
    .spif_target_en(spif_target_en));
  asc_frontend_model asc_frontend_model_i (.clock(clock), .rst_n(rst_n), .levels(levels),
    .run_a(run_a), .run_b(run_b), .filt_data(filt_data), .mclk_tick_a(mclk_tick_a),
    .mclk_tick_b(mclk_tick_b));

  // ************************************
  // clock, timeout and verdict
  // ************************************
  // free-running 100 mhz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // the whole run needs about two hundred cycles; a hang stops here
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      $display("[ERR] timeout expected %0d seen %0d", 0, cycles);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ************************************
  // bus and stimulus tasks
  // ************************************
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data is loaded at the edge that takes the strobe
  task automatic chk_reg(input string nm, input logic [6:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  task automatic raw(input logic [31:0] sel, input logic [31:0] e);
    wr(`ASC_ADR_SEL, sel);
    chk_reg("raw window", `ASC_ADR_RAW, e);
  endtask

  task automatic lvl(input int ch, input logic [15:0] v);
    @(posedge clock);
    levels[ch] <= v;
  endtask

  // n cycles of running gives n/4 ticks per running group
  task automatic run(input logic a, input logic b, input int n);
    @(posedge clock);
    run_a <= a;
    run_b <= b;
    repeat (n) @(posedge clock);
    run_a <= 1'b0;
    run_b <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset();
    chk_reg("decim", `ASC_ADR_DECIM, 32'h0100_0100);
    chk_reg("cal i0", `ASC_ADR_CAL0, 32'h0100_8000);
    chk_reg("brake thr", `ASC_ADR_BRAKE, 32'hFFFF_0000);
    chk_reg("stage", `ASC_ADR_STAGE, 32'h0000_0000);
    chk_reg("select", `ASC_ADR_SEL, 32'h0000_0000);
    chk_reg("unmapped", 7'h7F, 32'h0000_0000);
  endtask

  // every stage code once; current channel 0 runs single-ended (code 4),
  // channel 4 repeats code 4 and channel 7 repeats code 1
  task automatic t_stage();
    wr(`ASC_ADR_STAGE, 32'h1054_3214);
    repeat (2) @(posedge clock);
    #1;
    `CHK("stage word", 32'h1054_3214, input_stage_word)
    `CHK("neg to gnd", 8'h11, neg_to_gnd)
    `CHK("pos to gnd", 8'h82, pos_to_gnd)
    `CHK("ref sel", 8'h2C, ref_sel)
    wr(`ASC_ADR_STAGE, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1;
    `CHK("ref sel", 8'h00, ref_sel)
  endtask

  // i1 scaled by -1.0, w offset at full scale to force clipping
  task automatic t_samples();
    lvl(`ASC_CH_I0, 16'h9000);
    lvl(`ASC_CH_I1, 16'h8800);
    lvl(`ASC_CH_VM, 16'h4321);
    lvl(`ASC_CH_GPA, 16'h1111);
    lvl(`ASC_CH_GPB, 16'h2222);
    lvl(`ASC_CH_U, 16'hA000);
    lvl(`ASC_CH_V, 16'h7000);
    lvl(`ASC_CH_W, 16'h0000);
    wr(`ASC_ADR_DECIM, 32'h0001_0001);
    wr(`ASC_ADR_CAL0 + 7'h1, 32'hFF00_8000);
    wr(`ASC_ADR_CAL0 + 7'h4, 32'h0100_FFFF);
    run(1'b1, 1'b1, 8);
    raw(32'h0, 32'h8800_9000);
    raw(32'h1, 32'h1111_4321);
    raw(32'h2, 32'hA000_2222);
    raw(32'h3, 32'h0000_7000);
    raw(32'h4, 32'h0000_F800);
    chk_reg("res i", `ASC_ADR_RES_I, 32'hF800_1000);
    chk_reg("res i2", `ASC_ADR_RES_I2, 32'h0000_F800);
    chk_reg("res uv", `ASC_ADR_RES_UV, 32'hF000_2000);
    chk_reg("res w", `ASC_ADR_RES_W, 32'h0000_8001);
  endtask

  // two ticks at decimation three leave the sample, the third takes it
  task automatic t_decim();
    wr(`ASC_ADR_DECIM, 32'h0003_0003);
    lvl(`ASC_CH_I0, 16'hA000);
    run(1'b1, 1'b0, 8);
    raw(32'h0, 32'h8800_9000);
    run(1'b1, 1'b0, 4);
    raw(32'h0, 32'h8800_A000);
    chk_reg("res i", `ASC_ADR_RES_I, 32'hF800_2000);
    chk_reg("res i2", `ASC_ADR_RES_I2, 32'h0000_E800);
    wr(`ASC_ADR_DECIM, 32'h0001_0001);
  endtask

  task automatic t_ext();
    wr(`ASC_ADR_EXT, 32'h1234_5678);
    wr(`ASC_ADR_CTRL, 32'h0000_0003);
    run(1'b1, 1'b0, 4);
    raw(32'h0, 32'h1234_5678);
    `CHK("target", 16'h1111, spif_target)
    `CHK("target en", 1'b1, spif_target_en)
    wr(`ASC_ADR_CTRL, 32'h0000_0000);
    run(1'b1, 1'b0, 4);
    raw(32'h0, 32'h8800_A000);
    `CHK("target en", 1'b0, spif_target_en)
  endtask

  // on at or above 0x5000, off at or below 0x3000, held in between
  task automatic t_brake();
    wr(`ASC_ADR_BRAKE, 32'h5000_3000);
    lvl(`ASC_CH_VM, 16'h6000);
    run(1'b1, 1'b0, 4);
    `CHK("brake", 1'b1, brake_chopper)
    chk_reg("status", `ASC_ADR_STAT, 32'h0000_0001);
    lvl(`ASC_CH_VM, 16'h4000);
    run(1'b1, 1'b0, 4);
    `CHK("brake", 1'b1, brake_chopper)
    lvl(`ASC_CH_VM, 16'h2000);
    run(1'b1, 1'b0, 4);
    `CHK("brake", 1'b0, brake_chopper)
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    fails = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    levels = '0;
    run_a = 1'b0;
    run_b = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_stage();
    t_samples();
    t_decim();
    t_ext();
    t_brake();
    tally_and_finish();
  end
endmodule
`default_nettype wire
